// ### rtl/irs_pkg.sv
package irs_pkg;
  // register indices
  localparam logic [3:0] IDX_SEQ = 4'h0;
  localparam logic [3:0] IDX_NPIX = 4'h1;
  localparam logic [3:0] IDX_NLINE = 4'h2;
  localparam logic [3:0] IDX_INT = 4'h3;
  localparam logic [3:0] IDX_DELAY = 4'h4;
  localparam logic [3:0] IDX_XSTART = 4'h5;
  localparam logic [3:0] IDX_YSTART = 4'h6;
  // reset values
  localparam logic [11:0] RST_SEQ = 12'h000;
  localparam logic [10:0] RST_NPIX = 11'h200;
  localparam logic [11:0] RST_NLINE = 12'hbc6;
  localparam logic [11:0] RST_INT = 12'h001;
  localparam logic [7:0] RST_DELAY = 8'h03;
  localparam logic [6:0] RST_XSTART = 7'h00;
  localparam logic [7:0] RST_YSTART = 8'h00;
  // sequencer_config fields
  localparam int B_NDR = 0;
  localparam int B_MODE2 = 2;
  localparam int B_READF = 1;
  localparam int B_RSTBLK = 3;
  localparam int B_FAST = 4;
  localparam int B_FCAL = 5;
  localparam int B_LCAL = 6;
  localparam int B_CHARGE = 7;
  localparam int B_GRAN = 8;
  localparam int B_BLACK = 10;
  localparam int B_RSTALL = 11;
  // timing
  localparam logic [10:0] BLANK_MUL = 11'h046;
  localparam logic [10:0] BLANK_ADD = 11'h002;
  localparam logic [3:0] DLY_OFF = 4'h2;
  localparam logic [6:0] XSTART_MAX = 7'h62;
  typedef enum logic [2:0] {S_IDLE, S_SUSP, S_BLANK, S_READ, S_EOL} irs_state_t;
endpackage

// ### rtl/irs_seq.sv
`timescale 1ns/1ps
`default_nettype none
module irs_seq
  import irs_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // controller strobes
  input wire logic Y_CLOCK,
  input wire logic Y_START,
  // register port
  input wire logic REG_WE,
  input wire logic [3:0] REG_ADDR,
  input wire logic [11:0] REG_WDATA,
  output logic [11:0] REG_RDATA,
  // sync outputs
  output logic PIXEL_VALID,
  output logic END_OF_LINE,
  output logic END_OF_FRAME,
  // row addressing
  output logic LEFT_ROW_SYNC,
  output logic RIGHT_ROW_SYNC,
  output logic [7:0] LEFT_ROW_PTR,
  output logic [7:0] RIGHT_ROW_PTR,
  output logic ROW_READ_LEFT,
  output logic ROW_READ_RIGHT,
  output logic ROW_RESET,
  // column and analog controls
  output logic COL_CLOCK,
  output logic [10:0] COL_PAIR,
  output logic [6:0] COL_START,
  output logic AMP_CAL,
  output logic AMP_CAL_SLOW,
  output logic DARK_ON_RESET_BUS,
  output logic BLACK_LEVEL,
  output logic RESET_ALL_PIXELS,
  output logic COLUMN_CONTINUOUS_CHARGING,
  output logic SUSPENDED
);

  typedef struct packed {
    irs_state_t st;
    logic [11:0] seq;
    logic [10:0] npix;
    logic [11:0] nline;
    logic [11:0] intv;
    logic [7:0] dly;
    logic [6:0] xs;
    logic [7:0] ys;
    logic [11:0] rdata;
    logic yc_d;
    logic ys_d;
    logic phase;
    logic lfirst;
    logic rfirst;
    logic ract;
    logic [7:0] lptr;
    logic [7:0] rptr;
    logic [11:0] line;
    logic [11:0] intc;
    logic [10:0] cnt;
    logic [10:0] pix;
    logic colclk;
    logic lastl;
    logic firstrow;
    logic pvraw;
    logic eolraw;
    logic eofraw;
    logic [12:0] pvsh;
    logic [12:0] eolsh;
    logic [12:0] eofsh;
    logic pv;
    logic eol;
    logic eof;
    logic lsync;
    logic rsync;
    logic rdl;
    logic rdr;
    logic rrst;
    logic cal;
    logic cals;
    logic susp;
  } irs_regs_t;

  irs_regs_t s_r, s_nxt;

  function automatic logic [3:0] dly_code(input logic [3:0] c);
    dly_code = (c <= DLY_OFF) ? 4'h0 : c - DLY_OFF;
  endfunction

  function automatic logic tap(input logic [3:0] d, input logic now, input logic [12:0] sh);
    tap = (d == 4'h0) ? now : sh[d - 4'h1];
  endfunction

  logic nondestructive_enable, m2, m1, fast, ident, yc_rise, yc_fall, ys_rise, adv;
  logic [10:0] blen;
  logic [3:0] dpv, dend;

  always_comb begin
    nondestructive_enable = s_r.seq[B_NDR];
    m2 = nondestructive_enable & s_r.seq[B_MODE2];
    m1 = nondestructive_enable & ~s_r.seq[B_MODE2];
    fast = s_r.seq[B_FAST];
    ident = m1 | fast;
    yc_rise = Y_CLOCK & ~s_r.yc_d;
    yc_fall = ~Y_CLOCK & s_r.yc_d;
    ys_rise = Y_START & ~s_r.ys_d;
    adv = ~m2 | s_r.phase;
    blen = BLANK_MUL * (fast ? 11'h002 : (11'h002 << s_r.seq[B_GRAN+:2])) + BLANK_ADD;
    dpv = dly_code(s_r.dly[3:0]);
    dend = dly_code(s_r.dly[7:4]);
    s_nxt = s_r;
    s_nxt.yc_d = Y_CLOCK;
    s_nxt.ys_d = Y_START;
    s_nxt.lsync = 1'b0;
    s_nxt.rsync = 1'b0;
    s_nxt.eolraw = 1'b0;
    s_nxt.eofraw = 1'b0;
    if (REG_WE) begin
      unique case (REG_ADDR)
        IDX_SEQ: s_nxt.seq = REG_WDATA;
        IDX_NPIX: s_nxt.npix = REG_WDATA[10:0];
        IDX_NLINE: s_nxt.nline = REG_WDATA;
        IDX_INT: s_nxt.intv = REG_WDATA;
        IDX_DELAY: s_nxt.dly = REG_WDATA[7:0];
        IDX_XSTART: s_nxt.xs = (REG_WDATA[6:0] > XSTART_MAX) ? XSTART_MAX : REG_WDATA[6:0];
        IDX_YSTART: s_nxt.ys = REG_WDATA[7:0];
        default: ;
      endcase
    end
    unique case (REG_ADDR)
      IDX_SEQ: s_nxt.rdata = s_r.seq;
      IDX_NPIX: s_nxt.rdata = {1'b0, s_r.npix};
      IDX_NLINE: s_nxt.rdata = s_r.nline;
      IDX_INT: s_nxt.rdata = s_r.intv;
      IDX_DELAY: s_nxt.rdata = {4'h0, s_r.dly};
      IDX_XSTART: s_nxt.rdata = {5'h00, s_r.xs};
      IDX_YSTART: s_nxt.rdata = {4'h0, s_r.ys};
      default: s_nxt.rdata = 12'h000;
    endcase
    if (ys_rise) begin
      s_nxt.lsync = 1'b1;
      s_nxt.lptr = s_r.ys;
      s_nxt.lfirst = 1'b1;
      s_nxt.line = 12'h000;
      s_nxt.intc = 12'h000;
      s_nxt.phase = 1'b0;
      s_nxt.firstrow = 1'b1;
      s_nxt.ract = ident;
      s_nxt.rsync = ident;
      s_nxt.rptr = s_r.ys;
      s_nxt.rfirst = 1'b1;
    end else if (yc_rise) begin
      if (~m2 | ~s_r.phase) begin
        s_nxt.lfirst = 1'b0;
        if (!s_r.lfirst) begin
          s_nxt.lptr = s_r.lptr + 8'h01;
        end
      end
      if (ident) begin
        s_nxt.rptr = s_nxt.lptr;
      end else if (s_r.ract & (~m2 | s_r.phase)) begin
        s_nxt.rfirst = 1'b0;
        if (!s_r.rfirst) begin
          s_nxt.rptr = s_r.rptr + 8'h01;
        end
      end
      if (m2) begin
        s_nxt.phase = ~s_r.phase;
      end
      s_nxt.rdl = ident | ~nondestructive_enable | ~s_r.phase;
      s_nxt.rdr = ident | (nondestructive_enable & s_r.phase) | (~nondestructive_enable & s_r.ract);
      if (m2) begin
        s_nxt.rrst = ~s_r.phase & (~s_r.seq[B_READF] | s_r.seq[B_RSTBLK]);
      end else if (m1) begin
        s_nxt.rrst = ~s_r.seq[B_READF] | s_r.seq[B_RSTBLK];
      end else begin
        s_nxt.rrst = 1'b1;
      end
      if (adv) begin
        s_nxt.lastl = (s_r.line == s_r.nline);
        s_nxt.line = s_r.line + 12'h001;
        if (!s_r.ract) begin
          if (s_r.intc == s_r.intv) begin
            s_nxt.rsync = 1'b1;
            s_nxt.ract = 1'b1;
            s_nxt.rptr = s_r.ys;
            s_nxt.rfirst = 1'b1;
          end else begin
            s_nxt.intc = s_r.intc + 12'h001;
          end
        end
      end else begin
        s_nxt.lastl = 1'b0;
      end
    end
    unique case (s_r.st)
      S_IDLE, S_SUSP: begin
        if (Y_CLOCK) begin
          s_nxt.st = S_SUSP;
        end else if (yc_fall) begin
          s_nxt.st = S_BLANK;
          s_nxt.cnt = blen - 11'h001;
          s_nxt.cal = 1'b1;
          s_nxt.cals = s_r.firstrow ? s_r.seq[B_FCAL] : s_r.seq[B_LCAL];
          s_nxt.firstrow = 1'b0;
        end
      end
      S_BLANK: begin
        if (Y_CLOCK) begin
          s_nxt.st = S_SUSP;
          s_nxt.cal = 1'b0;
        end else if (s_r.cnt == 11'h000) begin
          s_nxt.st = S_READ;
          s_nxt.cal = 1'b0;
          s_nxt.pvraw = 1'b1;
          s_nxt.pix = 11'h000;
          s_nxt.colclk = 1'b0;
        end else begin
          s_nxt.cnt = s_r.cnt - 11'h001;
        end
      end
      S_READ: begin
        s_nxt.colclk = ~s_r.colclk;
        if (s_r.colclk) begin
          if (s_r.pix == s_r.npix) begin
            s_nxt.pvraw = 1'b0;
            s_nxt.st = S_EOL;
          end else begin
            s_nxt.pix = s_r.pix + 11'h001;
          end
        end
      end
      S_EOL: begin
        s_nxt.eolraw = 1'b1;
        s_nxt.eofraw = s_r.lastl;
        s_nxt.st = Y_CLOCK ? S_SUSP : S_IDLE;
      end
      default: s_nxt.st = S_IDLE;
    endcase
    s_nxt.susp = (s_nxt.st == S_SUSP);
    s_nxt.pvsh = {s_r.pvsh[11:0], s_r.pvraw};
    s_nxt.eolsh = {s_r.eolsh[11:0], s_r.eolraw};
    s_nxt.eofsh = {s_r.eofsh[11:0], s_r.eofraw};
    s_nxt.pv = tap(dpv, s_nxt.pvraw, s_nxt.pvsh);
    s_nxt.eol = tap(dend, s_nxt.eolraw, s_nxt.eolsh);
    s_nxt.eof = tap(dend, s_nxt.eofraw, s_nxt.eofsh);
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      s_r <= '0;
      s_r.st <= S_IDLE;
      s_r.seq <= RST_SEQ;
      s_r.npix <= RST_NPIX;
      s_r.nline <= RST_NLINE;
      s_r.intv <= RST_INT;
      s_r.dly <= RST_DELAY;
      s_r.xs <= RST_XSTART;
      s_r.ys <= RST_YSTART;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign REG_RDATA = s_r.rdata;
  assign PIXEL_VALID = s_r.pv;
  assign END_OF_LINE = s_r.eol;
  assign END_OF_FRAME = s_r.eof;
  assign LEFT_ROW_SYNC = s_r.lsync;
  assign RIGHT_ROW_SYNC = s_r.rsync;
  assign LEFT_ROW_PTR = s_r.lptr;
  assign RIGHT_ROW_PTR = s_r.rptr;
  assign ROW_READ_LEFT = s_r.rdl;
  assign ROW_READ_RIGHT = s_r.rdr;
  assign ROW_RESET = s_r.rrst;
  assign COL_CLOCK = s_r.colclk;
  assign COL_PAIR = s_r.pix;
  assign COL_START = s_r.xs;
  assign AMP_CAL = s_r.cal;
  assign AMP_CAL_SLOW = s_r.cals;
  assign DARK_ON_RESET_BUS = s_r.seq[B_NDR];
  assign BLACK_LEVEL = s_r.seq[B_BLACK];
  assign RESET_ALL_PIXELS = s_r.seq[B_RSTALL];
  assign COLUMN_CONTINUOUS_CHARGING = s_r.seq[B_CHARGE];
  assign SUSPENDED = s_r.susp;

  // checks
  mirror_rows_a: assert property (@(posedge CLOCK) disable iff (RST)
    (ident && $past(yc_rise)) |-> (s_r.rptr == s_r.lptr))
    else $error("row pointers differ in mirrored mode");
  alt_read_a: assert property (@(posedge CLOCK) disable iff (RST)
    (m2 && yc_rise && !ys_rise) |=> (s_r.rdl != s_r.rdr))
    else $error("mode 2 read not alternating");
  right_nores_a: assert property (@(posedge CLOCK) disable iff (RST)
    (m2 && s_r.phase && yc_rise && !ys_rise) |=> !s_r.rrst)
    else $error("right row reset in mode 2");
  blank_len_a: assert property (@(posedge CLOCK) disable iff (RST)
    (s_r.st == S_BLANK && $past(s_r.st) != S_BLANK) |-> (s_r.cnt == blen - 11'h001))
    else $error("blanking length wrong");
  pv_rise_a: assert property (@(posedge CLOCK) disable iff (RST)
    (s_r.st == S_BLANK && s_r.cnt == 11'h000 && !Y_CLOCK) |=> s_r.pvraw)
    else $error("pixel valid not raised after blanking");
  eol_after_a: assert property (@(posedge CLOCK) disable iff (RST)
    $fell(s_r.pvraw) |=> s_r.eolraw)
    else $error("end of line missing");
  half_rate_a: assert property (@(posedge CLOCK) disable iff (RST)
    (s_r.st == S_READ && $past(s_r.st) == S_READ) |-> (s_r.colclk != $past(s_r.colclk)))
    else $error("column clock not half rate");
  frame_load_a: assert property (@(posedge CLOCK) disable iff (RST)
    ys_rise |=> (s_r.lsync && s_r.lptr == $past(s_r.ys) && s_r.line == 12'h000))
    else $error("frame start did not load left row");
  pv_delay_a: assert property (@(posedge CLOCK) disable iff (RST)
    (s_r.dly[3:0] <= DLY_OFF && $stable(s_r.dly)) |-> (s_r.pv == s_r.pvraw))
    else $error("pixel valid delayed for small code");
endmodule
`default_nettype wire

// ### dv/irs_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module irs_ctrl_model (
  // clock
  input wire logic CLOCK,
  // strobes to the sequencer
  output logic Y_CLOCK,
  output logic Y_START
);
  initial begin
    Y_CLOCK = 1'b0;
    Y_START = 1'b0;
  end
  // frame start, held three cycles
  task automatic frame();
    @(posedge CLOCK);
    Y_START <= 1'b1;
    repeat (3) @(posedge CLOCK);
    Y_START <= 1'b0;
    repeat (2) @(posedge CLOCK);
  endtask
  // row advance, held one cycle
  task automatic row();
    @(posedge CLOCK);
    Y_CLOCK <= 1'b1;
    @(posedge CLOCK);
    Y_CLOCK <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### dv/image_row_frame_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module image_row_frame_sequencer_tb;
  import irs_pkg::*;
  logic CLOCK, RST, REG_WE, Y_CLOCK, Y_START, PIXEL_VALID, END_OF_LINE, END_OF_FRAME;
  logic [3:0] REG_ADDR;
  logic [11:0] REG_WDATA, REG_RDATA, q;
  logic [7:0] LEFT_ROW_PTR, RIGHT_ROW_PTR;
  logic LEFT_ROW_SYNC, RIGHT_ROW_SYNC, ROW_READ_LEFT, ROW_READ_RIGHT, ROW_RESET;
  logic COL_CLOCK, AMP_CAL, AMP_CAL_SLOW, DARK_ON_RESET_BUS, BLACK_LEVEL;
  logic RESET_ALL_PIXELS, COLUMN_CONTINUOUS_CHARGING, SUSPENDED;
  logic [10:0] COL_PAIR;
  logic [6:0] COL_START;
  logic eof, rl, rr, rs, slow, cp, sp;
  int errors, compares, blank, gap, pv, eg, n, tg, g0, lo, hi, nl, nr, nl0, nr0;
  logic [11:0] rv [8] = '{RST_SEQ, {1'b0, RST_NPIX}, RST_NLINE, RST_INT, {4'h0, RST_DELAY},
    {5'h00, RST_XSTART}, {4'h0, RST_YSTART}, 12'h000};
  int bt [4] = '{142, 282, 562, 1122};
  logic [11:0] m2 [3] = '{12'h005, 12'h007, 12'h00f};
  logic [7:0] dl [6] = '{8'h00, 8'h02, 8'h03, 8'hff, 8'h30, 8'hf0};

  irs_ctrl_model i_irs_ctrl_model (.CLOCK(CLOCK), .Y_CLOCK(Y_CLOCK), .Y_START(Y_START));
  irs_seq i_irs_seq (
    .CLOCK(CLOCK), .RST(RST), .Y_CLOCK(Y_CLOCK), .Y_START(Y_START), .REG_WE(REG_WE),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .PIXEL_VALID(PIXEL_VALID), .END_OF_LINE(END_OF_LINE), .END_OF_FRAME(END_OF_FRAME),
    .LEFT_ROW_SYNC(LEFT_ROW_SYNC), .RIGHT_ROW_SYNC(RIGHT_ROW_SYNC),
    .LEFT_ROW_PTR(LEFT_ROW_PTR), .RIGHT_ROW_PTR(RIGHT_ROW_PTR),
    .ROW_READ_LEFT(ROW_READ_LEFT), .ROW_READ_RIGHT(ROW_READ_RIGHT), .ROW_RESET(ROW_RESET),
    .COL_CLOCK(COL_CLOCK), .COL_PAIR(COL_PAIR), .COL_START(COL_START), .AMP_CAL(AMP_CAL),
    .AMP_CAL_SLOW(AMP_CAL_SLOW), .DARK_ON_RESET_BUS(DARK_ON_RESET_BUS),
    .BLACK_LEVEL(BLACK_LEVEL), .RESET_ALL_PIXELS(RESET_ALL_PIXELS),
    .COLUMN_CONTINUOUS_CHARGING(COLUMN_CONTINUOUS_CHARGING), .SUSPENDED(SUSPENDED)
  );

  // count row sync pulses
  always @(posedge CLOCK) begin
    nl += int'(LEFT_ROW_SYNC);
    nr += int'(RIGHT_ROW_SYNC);
  end

  task automatic summarize();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge CLOCK);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [11:0] d);
    @(posedge CLOCK);
    REG_WE <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLOCK);
    REG_WE <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge CLOCK);
    REG_ADDR <= a;
    repeat (2) @(posedge CLOCK);
    #1;
    q = REG_RDATA;
  endtask
  // one row strobe, then measure blanking, readout and end pulses
  task automatic line();
    i_irs_ctrl_model.row();
    #1;
    sp = SUSPENDED;
    n = 0;
    while (AMP_CAL !== 1'b1 && n < 100) begin
      tick();
      n++;
    end
    rl = ROW_READ_LEFT;
    rr = ROW_READ_RIGHT;
    rs = ROW_RESET;
    slow = AMP_CAL_SLOW;
    blank = 0;
    while (AMP_CAL === 1'b1 && blank < 2000) begin
      tick();
      blank++;
    end
    gap = 0;
    while (PIXEL_VALID !== 1'b1 && gap < 100) begin
      tick();
      gap++;
    end
    pv = 0;
    tg = 0;
    cp = COL_CLOCK;
    while (PIXEL_VALID === 1'b1 && pv < 5000) begin
      tick();
      pv++;
      tg += int'(COL_CLOCK !== cp);
      cp = COL_CLOCK;
    end
    eg = 0;
    while (END_OF_LINE !== 1'b1 && eg < 100) begin
      tick();
      eg++;
    end
    eof = END_OF_FRAME;
    tick();
  endtask

  initial begin
    CLOCK = 1'b0;
    forever #12.5 CLOCK = ~CLOCK;
  end
  initial begin
    repeat (60000) @(posedge CLOCK);
    errors++;
    summarize();
  end
  initial begin
    RST = 1'b1;
    REG_WE = 1'b0;
    REG_ADDR = 4'h0;
    REG_WDATA = 12'h000;
    repeat (4) @(posedge CLOCK);
    RST <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(4'(i));
      chk(q, rv[i]);
    end
    wr(4'h7, 12'hfff);
    rd(4'h7);
    chk(q, 12'h000);
    wr(IDX_XSTART, 12'h063);
    rd(IDX_XSTART);
    chk(q, {5'h00, XSTART_MAX});
    chk({5'h00, COL_START}, {5'h00, XSTART_MAX});
    wr(IDX_SEQ, 12'hc81);
    rd(IDX_SEQ);
    chk(q, 12'hc81);
    chk(12'({DARK_ON_RESET_BUS, COLUMN_CONTINUOUS_CHARGING}), 12'h003);
    chk(12'({BLACK_LEVEL, RESET_ALL_PIXELS}), 12'h003);
    wr(IDX_NPIX, 12'h003);
    wr(IDX_NLINE, 12'h002);
    wr(IDX_DELAY, 12'h000);
    wr(IDX_YSTART, 12'h005);
    for (int g = 0; g < 4; g++) begin
      wr(IDX_SEQ, 12'(g * 256 + 32));
      i_irs_ctrl_model.frame();
      chk({4'h0, LEFT_ROW_PTR}, 12'h005);
      line();
      chk(12'(blank), 12'(bt[g]));
      chk(12'(slow), 12'h001);
      chk(12'(sp), 12'h001);
      line();
      chk(12'(slow), 12'h000);
      chk({1'b0, COL_PAIR}, 12'h003);
      chk(12'(pv), 12'h008);
      chk(12'(eg), 12'h001);
      chk(12'(tg >= pv - 1), 12'h001);
    end
    wr(IDX_SEQ, 12'h000);
    wr(IDX_YSTART, 12'h009);
    nl0 = nl;
    nr0 = nr;
    i_irs_ctrl_model.frame();
    chk(12'(nl - nl0), 12'h001);
    for (int k = 0; k < 3; k++) begin
      line();
      chk(12'(eof), 12'(k == 2));
      if (k == 0)
        chk({4'h0, RIGHT_ROW_PTR}, 12'h009);
      if (k == 1)
        chk({4'h0, 8'(LEFT_ROW_PTR - RIGHT_ROW_PTR)}, RST_INT);
    end
    chk(12'(nr - nr0), 12'h001);
    for (int m = 0; m < 3; m++) begin
      wr(IDX_SEQ, m2[m]);
      i_irs_ctrl_model.frame();
      for (int k = 0; k < 6; k++) begin
        line();
        chk(12'({rl, rr, rs, eof}), 12'({k % 2 == 0, k % 2 == 1, k % 2 == 0 && m != 1, k == 5}));
      end
    end
    for (int m = 0; m < 2; m++) begin
      wr(IDX_SEQ, m == 0 ? 12'h001 : 12'h010);
      i_irs_ctrl_model.frame();
      line();
      line();
      chk(12'({rl === rr, LEFT_ROW_PTR === RIGHT_ROW_PTR}), 12'h003);
    end
    wr(IDX_SEQ, 12'h000);
    for (int i = 0; i < 6; i++) begin
      wr(IDX_DELAY, {4'h0, dl[i]});
      i_irs_ctrl_model.frame();
      line();
      if (i == 0)
        g0 = gap;
      lo = dl[i][3:0] > 4'h2 ? int'(dl[i][3:0]) - 2 : 0;
      hi = dl[i][7:4] > 4'h2 ? int'(dl[i][7:4]) - 2 : 0;
      chk(12'(gap), 12'(g0 + lo));
      chk(12'(eg), 12'(1 + hi - lo));
    end
    summarize();
  end
endmodule
`default_nettype wire
